/* File: common/pfh_pkg.sv */
// Constants shared by the parallel flash host controller.
// Assumes a 32-bit APB register port and a 200 MHz pclk.
package pfh_pkg;
  localparam int unsigned CLK_NS = 5;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  localparam int unsigned CTRL_OP_LSB  = 0;
  localparam int unsigned CTRL_GO      = 3;
  localparam int unsigned CTRL_BYPASS  = 4;
  localparam int unsigned CTRL_A9HV    = 5;
  localparam int unsigned CTRL_TEMPUNP = 6;

  localparam int unsigned ST_BUSY      = 0;
  localparam int unsigned ST_READY_PIN = 1;
  localparam int unsigned ST_CUT       = 2;
  localparam int unsigned ST_RDATA_LSB = 8;

  localparam logic [2:0] OP_READ      = 3'h0;
  localparam logic [2:0] OP_WRITE     = 3'h1;
  localparam logic [2:0] OP_PROG      = 3'h2;
  localparam logic [2:0] OP_RESET     = 3'h3;
  localparam logic [2:0] OP_PROTECT   = 3'h4;
  localparam logic [2:0] OP_UNPROTECT = 3'h5;

  localparam int unsigned ACCESS_NS        = 70;
  localparam int unsigned WE_PULSE_NS      = 35;
  localparam int unsigned INIT_PULSE_NS    = 500;
  localparam int unsigned INIT_RECOVERY_NS = 20000;

  localparam logic [19:0] UNLOCK1_ADDR = 20'h00555;
  localparam logic [19:0] UNLOCK2_ADDR = 20'h002aa;
  localparam logic [7:0]  UNLOCK1_DATA = 8'haa;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  PROG_SETUP   = 8'ha0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_WR_SET, ST_WR_LOW, ST_WR_HOLD, ST_WAIT_RDY, ST_RST_LOW, ST_RST_REC
  } pfh_state_t;
endpackage

/* File: design/pfh_ctrl.sv */
// Host controller that drives a byte-wide parallel NOR flash through its pins.
// Software commands it over APB; the flash pins are taken as synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module pfh_ctrl #(
  parameter int unsigned ACCESS_NS        = pfh_pkg::ACCESS_NS,
  parameter int unsigned WE_PULSE_NS      = pfh_pkg::WE_PULSE_NS,
  parameter int unsigned INIT_PULSE_NS    = pfh_pkg::INIT_PULSE_NS,
  parameter int unsigned INIT_RECOVERY_NS = pfh_pkg::INIT_RECOVERY_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [19:0]      flash_addr,
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  input  wire logic [7:0]  dq_in,
  output logic             chip_select_n,
  output logic             output_gate_n,
  output logic             write_strobe_n,
  output logic             hard_init_n,
  output logic             hv_reset_en,
  output logic             hv_a9_en,
  output logic             hv_oe_en,
  input  wire logic        op_done_indicator
);
  localparam int unsigned CW = 16;
  localparam int unsigned ACC_CYC = (ACCESS_NS + pfh_pkg::CLK_NS - 1) / pfh_pkg::CLK_NS;
  localparam int unsigned WE_CYC = (WE_PULSE_NS + pfh_pkg::CLK_NS - 1) / pfh_pkg::CLK_NS;
  localparam int unsigned RP_CYC = (INIT_PULSE_NS + pfh_pkg::CLK_NS - 1) / pfh_pkg::CLK_NS;
  localparam int unsigned RDY_CYC =
    (INIT_RECOVERY_NS + pfh_pkg::CLK_NS - 1) / pfh_pkg::CLK_NS;

  if (ACC_CYC < 1 || WE_CYC < 1 || RP_CYC < 8 || RDY_CYC < 8 || RDY_CYC >= (1 << CW))
  begin : g_bad_timing
    $error("pfh_ctrl: timing parameters out of range");
  end

  pfh_pkg::pfh_state_t state;
  pfh_pkg::pfh_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [1:0]    step;
  logic [2:0]    op;
  logic          bypass;
  logic          a9hv;
  logic          tempunp;
  logic          cut;
  logic [19:0]   addr_reg;
  logic [7:0]    wdata_reg;
  logic [7:0]    rdata_reg;

  // Register port decode.
  wire acc      = psel && penable;
  wire wr_en    = acc && pwrite;
  wire hit_ctrl = paddr == pfh_pkg::REG_CTRL;
  wire hit_addr = paddr == pfh_pkg::REG_ADDR;
  wire hit_wdat = paddr == pfh_pkg::REG_WDATA;
  wire hit_stat = paddr == pfh_pkg::REG_STATUS;
  wire hit      = hit_ctrl || hit_addr || hit_wdat || hit_stat;
  wire idle     = state == pfh_pkg::ST_IDLE;
  wire busy     = !idle;
  wire ctrl_wr  = wr_en && hit_ctrl && idle;
  wire start    = ctrl_wr && pwdata[pfh_pkg::CTRL_GO];
  wire [2:0] new_op = pwdata[pfh_pkg::CTRL_OP_LSB +: 3];
  wire clr_cut  = wr_en && hit_stat && pwdata[pfh_pkg::ST_CUT];
  wire set_cut  = start && new_op == pfh_pkg::OP_RESET && !op_done_indicator;

  wire [31:0] ctrl_rd = {25'h0, tempunp, a9hv, bypass, 1'b0, op};
  wire [31:0] stat_rd = {16'h0, rdata_reg, 5'h0, cut, op_done_indicator, busy};
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata  = hit_ctrl ? ctrl_rd :
                   hit_addr ? {12'h0, addr_reg} :
                   hit_wdat ? {24'h0, wdata_reg} :
                   hit_stat ? stat_rd : 32'h0;

  // Operation selection and the program sequence: four steps, or two in bypass mode.
  wire is_prog   = op == pfh_pkg::OP_PROG;
  wire is_prot   = op == pfh_pkg::OP_PROTECT;
  wire is_unprot = op == pfh_pkg::OP_UNPROTECT;
  wire is_pmode  = is_prot || is_unprot;
  wire last_step = !is_prog || step == 2'd3;
  wire [1:0] first_step = (new_op == pfh_pkg::OP_PROG && !pwdata[pfh_pkg::CTRL_BYPASS]) ?
                          2'd0 : 2'd2;
  wire [19:0] prot_addr = {addr_reg[19:7], is_unprot, addr_reg[5:2], 2'b10};
  wire [19:0] prog_addr = step == 2'd0 ? pfh_pkg::UNLOCK1_ADDR :
                          step == 2'd1 ? pfh_pkg::UNLOCK2_ADDR :
                          (step == 2'd2 && !bypass) ? pfh_pkg::UNLOCK1_ADDR : addr_reg;
  wire [7:0]  prog_data = step == 2'd0 ? pfh_pkg::UNLOCK1_DATA :
                          step == 2'd1 ? pfh_pkg::UNLOCK2_DATA :
                          step == 2'd2 ? pfh_pkg::PROG_SETUP : wdata_reg;
  wire [19:0] cyc_addr  = is_pmode ? prot_addr : is_prog ? prog_addr : addr_reg;
  wire [7:0]  cyc_data  = is_prog ? prog_data : wdata_reg;

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt == '0 ? cnt : cnt - 1'b1;
    case (state)
      pfh_pkg::ST_IDLE:
        if (start)
        begin
          case (new_op)
            pfh_pkg::OP_READ:
            begin
              next_state = pfh_pkg::ST_RD;
              next_cnt   = CW'(ACC_CYC - 1);
            end
            pfh_pkg::OP_RESET:
            begin
              next_state = pfh_pkg::ST_RST_LOW;
              next_cnt   = CW'(RP_CYC - 1);
            end
            pfh_pkg::OP_WRITE, pfh_pkg::OP_PROG, pfh_pkg::OP_PROTECT, pfh_pkg::OP_UNPROTECT:
              next_state = pfh_pkg::ST_WR_SET;
            default:
              next_state = pfh_pkg::ST_IDLE;
          endcase
        end
      pfh_pkg::ST_RD:
        if (cnt == '0)
          next_state = pfh_pkg::ST_IDLE;
      pfh_pkg::ST_WR_SET:
      begin
        next_state = pfh_pkg::ST_WR_LOW;
        next_cnt   = CW'(WE_CYC);
      end
      pfh_pkg::ST_WR_LOW:
        if (cnt == '0)
          next_state = pfh_pkg::ST_WR_HOLD;
      pfh_pkg::ST_WR_HOLD:
        next_state = !last_step ? pfh_pkg::ST_WR_SET :
                     is_prog ? pfh_pkg::ST_WAIT_RDY : pfh_pkg::ST_IDLE;
      pfh_pkg::ST_WAIT_RDY:
        if (op_done_indicator)
          next_state = pfh_pkg::ST_IDLE;
      pfh_pkg::ST_RST_LOW:
        if (cnt == '0)
        begin
          next_state = pfh_pkg::ST_RST_REC;
          next_cnt   = CW'(RDY_CYC - 1);
        end
      pfh_pkg::ST_RST_REC:
        if (cnt == '0 && op_done_indicator)
          next_state = pfh_pkg::ST_IDLE;
      default:
        next_state = pfh_pkg::ST_IDLE;
    endcase
  end

  // Pins come from flip-flops; address and data lead the write strobe by one cycle.
  wire n_rd     = next_state == pfh_pkg::ST_RD;
  wire n_wlow   = next_state == pfh_pkg::ST_WR_LOW;
  wire n_wcyc   = n_wlow || next_state == pfh_pkg::ST_WR_SET || next_state == pfh_pkg::ST_WR_HOLD;
  wire n_a9oe   = a9hv && is_pmode && (n_wcyc || next_state == pfh_pkg::ST_WR_HOLD);
  wire n_isprot = !a9hv && is_pmode && (n_wcyc || next_state == pfh_pkg::ST_WR_HOLD);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state          <= pfh_pkg::ST_IDLE;
      cnt            <= '0;
      step           <= 2'd0;
      op             <= pfh_pkg::OP_READ;
      bypass         <= 1'b0;
      a9hv           <= 1'b0;
      tempunp        <= 1'b0;
      cut            <= 1'b0;
      addr_reg       <= 20'h0;
      wdata_reg      <= 8'h0;
      rdata_reg      <= 8'h0;
      chip_select_n  <= 1'b1;
      output_gate_n  <= 1'b1;
      write_strobe_n <= 1'b1;
      hard_init_n    <= 1'b1;
      hv_reset_en    <= 1'b0;
      hv_a9_en       <= 1'b0;
      hv_oe_en       <= 1'b0;
      dq_oe          <= 1'b0;
      dq_out         <= 8'h0;
      flash_addr     <= 20'h0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      if (ctrl_wr)
      begin
        op      <= new_op;
        bypass  <= pwdata[pfh_pkg::CTRL_BYPASS];
        a9hv    <= pwdata[pfh_pkg::CTRL_A9HV];
        tempunp <= pwdata[pfh_pkg::CTRL_TEMPUNP];
      end
      if (wr_en && hit_addr && idle)
        addr_reg <= pwdata[19:0];
      if (wr_en && hit_wdat && idle)
        wdata_reg <= pwdata[7:0];
      cut <= set_cut || (cut && !clr_cut);
      if (start)
        step <= first_step;
      else if (state == pfh_pkg::ST_WR_HOLD && !last_step)
        step <= step + 2'd1;
      if (state == pfh_pkg::ST_RD && cnt == '0)
        rdata_reg <= dq_in;
      chip_select_n  <= !(n_rd || n_wcyc);
      output_gate_n  <= !n_rd;
      write_strobe_n <= !(n_wlow && state == pfh_pkg::ST_WR_LOW);
      dq_oe          <= n_wcyc;
      dq_out         <= (state == pfh_pkg::ST_WR_SET) ? cyc_data : dq_out;
      flash_addr     <= n_rd ? addr_reg : (state == pfh_pkg::ST_WR_SET) ? cyc_addr : flash_addr;
      hard_init_n    <= next_state != pfh_pkg::ST_RST_LOW;
      hv_reset_en    <= (tempunp && next_state != pfh_pkg::ST_RST_LOW) || n_isprot;
      hv_a9_en       <= (a9hv && n_rd) || n_a9oe;
      hv_oe_en       <= n_a9oe;
    end
  end

  // Helper count of write strobes within one operation.
  logic [2:0] we_falls;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      we_falls <= 3'd0;
    else if (start)
      we_falls <= 3'd0;
    else if (state == pfh_pkg::ST_WR_SET)
      we_falls <= we_falls + 3'd1;
  end

  AST_RD_STROBES: assert property (@(posedge pclk) disable iff (!presetn)
    !output_gate_n |-> !chip_select_n && write_strobe_n)
    else $error("read strobes wrong");
  AST_WR_STROBES: assert property (@(posedge pclk) disable iff (!presetn)
    !write_strobe_n |-> !chip_select_n && output_gate_n && dq_oe)
    else $error("write strobes wrong");
  AST_RD_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(output_gate_n) |-> !output_gate_n [*2])
    else $error("read pulse too short");
  AST_PROG_WRITES: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pfh_pkg::ST_WR_HOLD && is_prog && last_step) |->
      we_falls == (bypass ? 3'd2 : 3'd4))
    else $error("program write count wrong");
  AST_RST_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(hard_init_n) |-> !hard_init_n [*8])
    else $error("reset pulse too short");
  AST_RST_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    !hard_init_n |-> chip_select_n && write_strobe_n && output_gate_n && !dq_oe)
    else $error("access during reset pulse");
  AST_RECOVERY: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(hard_init_n) |-> busy [*8])
    else $error("recovery wait skipped");
  AST_PROT_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    (!write_strobe_n && is_prot) |-> flash_addr[6] == 1'b0 && flash_addr[1:0] == 2'b10)
    else $error("protect address pattern wrong");
  AST_UNPROT_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    (!write_strobe_n && is_unprot) |-> flash_addr[6] && flash_addr[1:0] == 2'b10)
    else $error("unprotect address pattern wrong");
  AST_HV_METHOD: assert property (@(posedge pclk) disable iff (!presetn)
    (!write_strobe_n && is_pmode) |-> (hv_a9_en && hv_oe_en) != hv_reset_en || tempunp)
    else $error("elevated level method wrong");
  AST_CUT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    set_cut |=> cut)
    else $error("cut flag lost");

  COV_READ: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(output_gate_n));
  COV_PROG: cover property (@(posedge pclk) disable iff (!presetn)
    state == pfh_pkg::ST_WAIT_RDY ##1 idle);
  COV_BYPASS: cover property (@(posedge pclk) disable iff (!presetn)
    state == pfh_pkg::ST_WR_HOLD && is_prog && bypass && last_step);
  COV_RESET: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(hard_init_n));
endmodule
`default_nettype wire

/* File: bench/pfh_flash_model.sv */
// Behavioural byte-wide NOR flash on the far side of the host controller.
// Assumes pins change in step with pclk; 256-byte array, sector from address bits 19:16.
`timescale 1ns/1ps
`default_nettype none
module pfh_flash_model #(
  parameter int unsigned PROG_NS = 300,
  parameter int unsigned REC_NS  = 200,
  parameter logic [7:0]  MAKER   = 8'h5a, // Arbitrary value.
  parameter logic [7:0]  PART    = 8'hc3  // Arbitrary value.
) (
  input  wire logic [19:0] flash_addr,
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe,
  output logic [7:0]       dq_in,
  input  wire logic        chip_select_n,
  input  wire logic        output_gate_n,
  input  wire logic        write_strobe_n,
  input  wire logic        hard_init_n,
  input  wire logic        hv_reset_en,
  input  wire logic        hv_a9_en,
  input  wire logic        hv_oe_en,
  input  wire logic        bypass_mode,
  input  wire logic        start_long_op,
  output logic             op_done_indicator
);
  logic [7:0]  mem [256];
  logic [15:0] prot = 16'h0;
  logic [19:0] ca;
  logic [1:0]  step = 2'd0;
  logic [7:0]  last = 8'h00;
  logic [7:0]  rd;
  event        prog_go;
  wire         wr_n  = write_strobe_n | chip_select_n | ~output_gate_n;
  wire         drive = !chip_select_n && !output_gate_n && write_strobe_n &&
                       hard_init_n;
  wire         hv    = hv_reset_en || (hv_a9_en && hv_oe_en);
  initial foreach (mem[i]) mem[i] = 8'hff;
  assign rd = hv_a9_en ? (flash_addr[1:0] == 2'b00 ? MAKER : flash_addr[1:0] == 2'b01 ? PART
              : {7'h0, prot[flash_addr[19:16]]}) : mem[flash_addr[7:0]];
  // A released bus shows the inverse of its last value, never a kind guess.
  assign dq_in = dq_oe ? dq_out : drive ? rd : ~last;
  always_latch if (drive || dq_oe) last <= dq_in;
  always @(negedge wr_n) ca = flash_addr;
  always @(posedge wr_n)
    if (hard_init_n === 1'b1)
    begin
      if (hv && step == 2'd0 && dq_in != 8'haa && dq_in != 8'ha0 && ca[1:0] == 2'b10)
        prot = ca[6] ? 16'h0 : (prot | (16'h1 << ca[19:16]));
      else if (step == 2'd3)
      begin
        if (!prot[ca[19:16]] || hv_reset_en) mem[ca[7:0]] = dq_in;
        step = 2'd0;
        -> prog_go;
      end
      else if (dq_in == pfh_pkg::PROG_SETUP && (step == 2'd2 || bypass_mode)) step = 2'd3;
      else if (step == 2'd0 && ca == pfh_pkg::UNLOCK1_ADDR && dq_in == pfh_pkg::UNLOCK1_DATA) step = 2'd1;
      else if (step == 2'd1 && ca == pfh_pkg::UNLOCK2_ADDR && dq_in == pfh_pkg::UNLOCK2_DATA) step = 2'd2;
      else step = 2'd0;
    end
  always @(negedge hard_init_n) step = 2'd0;
  always
  begin
    op_done_indicator = 1'b1;
    @(prog_go or posedge start_long_op);
    op_done_indicator = 1'b0;
    fork
      #(PROG_NS + 1);
      @(negedge hard_init_n);
    join_any
    disable fork;
    if (hard_init_n !== 1'b1)
    begin
      @(posedge hard_init_n);
      #(REC_NS + 1);
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_parallel_flash_bus_modes.sv */
// Self-checking bench for the parallel flash host controller against a flash model.
// Assumes the APB map of pfh_pkg and a shortened reset pulse and recovery.
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_flash_bus_modes;
  localparam int         RP    = 40 / pfh_pkg::CLK_NS;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value.
  localparam logic [7:0] PART  = 8'hc3; // Arbitrary value.
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        bypass_mode = 1'b0;
  logic        start_long_op = 1'b0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, rerr, dq_oe, cs_n, oe_n, we_n, rst_n, hv_r, hv_a, hv_o, rdy;
  logic [19:0] fa;
  logic [7:0]  dq_out, dq_in, rb;
  int          fail_count = 0, checks_done = 0, wr_cnt = 0, rp_cnt = 0, cycles = 0;
  always #(pfh_pkg::CLK_NS / 2.0) pclk = ~pclk;
  pfh_ctrl #(.INIT_PULSE_NS(40), .INIT_RECOVERY_NS(200)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(fa), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in), .chip_select_n(cs_n), .output_gate_n(oe_n),
    .write_strobe_n(we_n), .hard_init_n(rst_n), .hv_reset_en(hv_r), .hv_a9_en(hv_a),
    .hv_oe_en(hv_o), .op_done_indicator(rdy));
  pfh_flash_model #(.REC_NS(200), .MAKER(MAKER), .PART(PART)) flash (.flash_addr(fa),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .chip_select_n(cs_n), .output_gate_n(oe_n),
    .write_strobe_n(we_n), .hard_init_n(rst_n), .hv_reset_en(hv_r), .hv_a9_en(hv_a),
    .hv_oe_en(hv_o), .bypass_mode(bypass_mode), .start_long_op(start_long_op),
    .op_done_indicator(rdy));
  always @(negedge we_n) wr_cnt++;
  always @(posedge pclk)
  begin
    cycles++;
    if (rst_n === 1'b0) rp_cnt++;
    if (cycles == 40000)
    begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] op, input logic [2:0] mode);
    return {25'h0, mode, 1'b1, op};
  endfunction
  function automatic logic [7:0] expect_byte(input logic p, input logic t, input logic [7:0] o,
                                             input logic [7:0] n);
    return (p && !t) ? o : n;
  endfunction
  task automatic run(input logic [31:0] c, input logic [19:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, pfh_pkg::REG_ADDR, {12'h0, a});
    apb(1'b1, pfh_pkg::REG_WDATA, {24'h0, d});
    wr_cnt = 0;
    rp_cnt = 0;
    apb(1'b1, pfh_pkg::REG_CTRL, c);
    n = 0;
    do
    begin
      apb(1'b0, pfh_pkg::REG_STATUS, 32'h0);
      n++;
    end
    while (rdata[pfh_pkg::ST_BUSY] !== 1'b0 && n < 3000);
    check("operation finished", {31'h0, rdata[pfh_pkg::ST_BUSY]}, 32'h0);
    rb = rdata[15:8];
  endtask
  task automatic prog(input logic [19:0] a, input logic [7:0] d, input logic [2:0] m);
    bypass_mode <= m[0];
    run(ctl(pfh_pkg::OP_PROG, m), a, d);
  endtask
  task automatic chk_rd(input string name, input logic [19:0] a, input logic hv, input logic [7:0] e);
    run(ctl(pfh_pkg::OP_READ, {1'b0, hv, 1'b0}), a, 8'h00);
    check(name, {24'h0, rb}, {24'h0, e});
  endtask
  initial
  begin
    logic [19:0] a;
    logic [7:0]  d;
    void'($urandom(32'h55fa));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check("pins after reset", {24'h0, cs_n, oe_n, we_n, rst_n, hv_r, hv_a, hv_o, dq_oe}, 32'hf0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", {31'h0, rerr}, 32'h1);
    a = 20'($urandom);
    apb(1'b1, pfh_pkg::REG_ADDR, {12'h0, a});
    apb(1'b0, pfh_pkg::REG_ADDR, 32'h0);
    check("address register", rdata, {12'h0, a});
    chk_rd("erased read", a, 1'b0, 8'hff);
    $display("test reset_and_registers done");
    for (int i = 0; i < 6; i++)
    begin
      a = {4'(1 + $urandom % 15), 8'h00, 8'(i)};
      d = 8'($urandom);
      prog(a, d, {2'b00, i[0]});
      check("write cycles", wr_cnt, i[0] ? 32'd2 : 32'd4);
      chk_rd("read back", a, 1'b0, d);
    end
    $display("test program done");
    chk_rd("maker code", 20'h00000, 1'b1, MAKER);
    chk_rd("part code", 20'h00001, 1'b1, PART);
    run(ctl(pfh_pkg::OP_PROTECT, 3'b000), 20'h00000, 8'h60);
    chk_rd("protect flag", 20'h00002, 1'b1, 8'h01);
    prog(20'h00020, 8'h3c, 3'b000);
    chk_rd("refused program", 20'h00020, 1'b0, expect_byte(1'b1, 1'b0, 8'hff, 8'h3c));
    prog(20'h00020, 8'h3c, 3'b100);
    chk_rd("temporary unprotect", 20'h00020, 1'b0, expect_byte(1'b1, 1'b1, 8'hff, 8'h3c));
    chk_rd("protect restored", 20'h00002, 1'b1, 8'h01);
    run(ctl(pfh_pkg::OP_PROTECT, 3'b010), 20'h20000, 8'h60);
    chk_rd("alternate protect", 20'h20002, 1'b1, 8'h01);
    run(ctl(pfh_pkg::OP_UNPROTECT, 3'b010), 20'h00000, 8'h60);
    chk_rd("unprotect first", 20'h00002, 1'b1, 8'h00);
    chk_rd("unprotect other", 20'h20002, 1'b1, 8'h00);
    prog(20'h20021, 8'h99, 3'b000);
    chk_rd("program after unprotect", 20'h20021, 1'b0, expect_byte(1'b0, 1'b0, 8'hff, 8'h99));
    $display("test protection done");
    run(ctl(pfh_pkg::OP_RESET, 3'b000), 20'h00000, 8'h00);
    check("reset pulse cycles", rp_cnt, RP);
    check("status after reset", {29'h0, rdata[2:0]}, 32'h2);
    chk_rd("read after reset", 20'h20021, 1'b0, 8'h99);
    start_long_op <= 1'b1;
    run(ctl(pfh_pkg::OP_RESET, 3'b000), 20'h00000, 8'h00);
    start_long_op <= 1'b0;
    check("cut after busy reset", {29'h0, rdata[2:0]}, 32'h6);
    apb(1'b1, pfh_pkg::REG_STATUS, 32'h4);
    apb(1'b0, pfh_pkg::REG_STATUS, 32'h0);
    check("cut cleared", {29'h0, rdata[2:0]}, 32'h2);
    $display("test hardware_reset done");
    finish_test();
  end
endmodule
`default_nettype wire
